// >>> common/mvx_params.svh
// Purpose: named offsets, reset values and timing counts of the external data path
// Assumes: included by bare name from design and assertion files
// Notes: counts are in core clocks unless said otherwise
`ifndef MVX_PARAMS_SVH
`define MVX_PARAMS_SVH
`define MVX_OFF_PTR0_LO 8'h82
`define MVX_OFF_PTR0_HI 8'h83
`define MVX_OFF_PTR1_LO 8'h84
`define MVX_OFF_PTR1_HI 8'h85
`define MVX_OFF_SELECT 8'h86
`define MVX_OFF_CLKCTL 8'h8E
`define MVX_STRETCH_RESET 3'h1
`define MVX_SELECT_RESET 1'b0
`define MVX_PTR_RESET 16'h0000
`define MVX_BYTE_ZERO 8'h00
`define MVX_CLKS_PER_MC 6'h04
`define MVX_MIN_MC 6'h02
`define MVX_FAST_STROBE_START 6'h05
`define MVX_FAST_STROBE_CLKS 6'h02
`define MVX_SLOW_STROBE_START 6'h04
`define MVX_ALE_CLKS 6'h02
`define MVX_ADDR_DRIVE_CLKS 6'h03
`define MVX_CNT_FIRST 6'h00
`define MVX_CNT_STEP 6'h01
`endif

// >>> common/mvx_pkg.sv
// Purpose: shared types of the external data move path
// Assumes: mvx_params.svh holds the offsets and counts; widths and state codes stand here
// Notes: sequencer states follow a gray path idle, addr, strobe, recov
package mvx_pkg;
    typedef logic [5:0] mvx_count_t;
    typedef logic [2:0] mvx_stretch_t;
    typedef logic [7:0] mvx_byte_t;
    typedef logic [15:0] mvx_addr_t;
    typedef enum logic [1:0]
    {
        mvx_st_idle = 2'b00,
        mvx_st_addr = 2'b01,
        mvx_st_strobe = 2'b11,
        mvx_st_recov = 2'b10
    } mvx_state_t;
endpackage : mvx_pkg

// >>> common/mvx_if.sv
// Purpose: carriers between the top and its register and timing modules
// Assumes: one clock domain
// Notes: no clocking blocks
`timescale 1ns/1ns
interface mvx_reg_if;
    import mvx_pkg::*;
    mvx_byte_t sfr_addr;
    logic sfr_wr;
    mvx_byte_t sfr_wdata;
    mvx_byte_t sfr_rdata;
    logic [4:0] clkctl_upper;
    logic ptr_load;
    mvx_addr_t ptr_load_val;
    logic ptr_inc;
    mvx_addr_t active_ptr;
    mvx_stretch_t stretch;
    modport regs (input sfr_addr, sfr_wr, sfr_wdata, clkctl_upper, ptr_load, ptr_load_val,
                  ptr_inc, output sfr_rdata, active_ptr, stretch);
    modport core (output sfr_addr, sfr_wr, sfr_wdata, clkctl_upper, ptr_load, ptr_load_val,
                  ptr_inc, input sfr_rdata, active_ptr, stretch);
endinterface : mvx_reg_if

interface mvx_plan_if;
    import mvx_pkg::*;
    logic load;
    mvx_stretch_t stretch;
    mvx_count_t strobe_first;
    mvx_count_t strobe_last;
    mvx_count_t move_last;
    modport plan (input load, stretch, output strobe_first, strobe_last, move_last);
    modport core (output load, stretch, input strobe_first, strobe_last, move_last);
endinterface : mvx_plan_if

// >>> rtl/mvx_sfr_regs.sv
// Purpose: data pointers, pointer select and stretch field with their register port
// Assumes: register port writes take effect at the clock edge, reads answer next cycle
// Notes: register writes win over pointer load and increment in the same cycle
`timescale 1ns/1ns
`include "mvx_params.svh"
module mvx_sfr_regs
(
    input wire logic clk_in,
    input wire logic rst_in,
    mvx_reg_if.regs rif
);
    import mvx_pkg::*;

    function automatic logic hit(input mvx_byte_t a, input mvx_byte_t off);
        hit = (a == off);
    endfunction : hit

    mvx_addr_t ptr_q [2];
    mvx_addr_t ptr_d [2];
    logic sel_q, sel_d;
    mvx_stretch_t stretch_q, stretch_d;
    mvx_byte_t rdata_q, rdata_d;

    always_comb
    begin
        ptr_d = ptr_q;
        sel_d = sel_q;
        stretch_d = stretch_q;
        if (rif.ptr_load)
            ptr_d[sel_q] = rif.ptr_load_val;
        else if (rif.ptr_inc)
            ptr_d[sel_q] = 16'(ptr_q[sel_q] + 16'h0001);
        if (rif.sfr_wr)
        begin
            if (hit(rif.sfr_addr, `MVX_OFF_PTR0_LO)) ptr_d[0][7:0] = rif.sfr_wdata;
            if (hit(rif.sfr_addr, `MVX_OFF_PTR0_HI)) ptr_d[0][15:8] = rif.sfr_wdata;
            if (hit(rif.sfr_addr, `MVX_OFF_PTR1_LO)) ptr_d[1][7:0] = rif.sfr_wdata;
            if (hit(rif.sfr_addr, `MVX_OFF_PTR1_HI)) ptr_d[1][15:8] = rif.sfr_wdata;
            // an increment of the select register lands here as value plus one
            if (hit(rif.sfr_addr, `MVX_OFF_SELECT)) sel_d = rif.sfr_wdata[0];
            // upper control bits stay with timer and watchdog logic
            if (hit(rif.sfr_addr, `MVX_OFF_CLKCTL)) stretch_d = rif.sfr_wdata[2:0];
        end
        rdata_d = `MVX_BYTE_ZERO;
        if (hit(rif.sfr_addr, `MVX_OFF_PTR0_LO)) rdata_d = ptr_q[0][7:0];
        if (hit(rif.sfr_addr, `MVX_OFF_PTR0_HI)) rdata_d = ptr_q[0][15:8];
        if (hit(rif.sfr_addr, `MVX_OFF_PTR1_LO)) rdata_d = ptr_q[1][7:0];
        if (hit(rif.sfr_addr, `MVX_OFF_PTR1_HI)) rdata_d = ptr_q[1][15:8];
        if (hit(rif.sfr_addr, `MVX_OFF_SELECT)) rdata_d = {7'h00, sel_q};
        if (hit(rif.sfr_addr, `MVX_OFF_CLKCTL)) rdata_d = {rif.clkctl_upper, stretch_q};
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ptr_q[0] <= `MVX_PTR_RESET;
            ptr_q[1] <= `MVX_PTR_RESET;
            sel_q <= `MVX_SELECT_RESET;
            stretch_q <= `MVX_STRETCH_RESET;
            rdata_q <= `MVX_BYTE_ZERO;
        end
        else
        begin
            ptr_q <= ptr_d;
            sel_q <= sel_d;
            stretch_q <= stretch_d;
            rdata_q <= rdata_d;
        end
    end

    assign rif.active_ptr = ptr_q[sel_q];
    assign rif.stretch = stretch_q;
    assign rif.sfr_rdata = rdata_q;
endmodule : mvx_sfr_regs

// >>> rtl/mvx_cycle_plan.sv
// Purpose: turns a stretch value into strobe and move boundaries in clocks
// Assumes: load comes one cycle before the boundaries are first used
// Notes: values hold until the next load, so a mid-move rewrite has no effect
`timescale 1ns/1ns
`include "mvx_params.svh"
module mvx_cycle_plan
(
    input wire logic clk_in,
    input wire logic rst_in,
    mvx_plan_if.plan pif
);
    import mvx_pkg::*;

    mvx_count_t first_q, first_d, last_q, last_d, end_q, end_d;
    mvx_count_t s6;

    always_comb
    begin
        s6 = {3'h0, pif.stretch};
        first_d = first_q;
        last_d = last_q;
        end_d = end_q;
        if (pif.load)
        begin
            end_d = 6'(`MVX_CLKS_PER_MC * (s6 + `MVX_MIN_MC) - 6'h01);
            if (pif.stretch == 3'h0)
            begin
                first_d = `MVX_FAST_STROBE_START;
                last_d = 6'(`MVX_FAST_STROBE_START + `MVX_FAST_STROBE_CLKS - 6'h01);
            end
            else
            begin
                first_d = `MVX_SLOW_STROBE_START;
                last_d = 6'(`MVX_SLOW_STROBE_START + `MVX_CLKS_PER_MC * s6 - 6'h01);
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            first_q <= `MVX_SLOW_STROBE_START;
            last_q <= 6'(`MVX_SLOW_STROBE_START + `MVX_CLKS_PER_MC - 6'h01);
            end_q <= 6'(`MVX_CLKS_PER_MC * (`MVX_MIN_MC + 6'h01) - 6'h01);
        end
        else
        begin
            first_q <= first_d;
            last_q <= last_d;
            end_q <= end_d;
        end
    end

    assign pif.strobe_first = first_q;
    assign pif.strobe_last = last_q;
    assign pif.move_last = end_q;
endmodule : mvx_cycle_plan

// >>> rtl/mvx_top.sv
// Purpose: external data move sequencer with dual data pointers and stretch control
// Assumes: core inputs are synchronous to clk_in; one request per idle period
// Notes: program fetch timing lives elsewhere and never sees the stretch field
`timescale 1ns/1ns
`include "mvx_params.svh"
// Function
// - stretch value sits in bits 2 to 0 of the clock control register.
// - stretch zero gives a two machine cycle move, two clock strobe.
// - move lasts stretch plus two machine cycles, up to nine.
// - stretch one to seven gives a strobe of four clocks per step.
// - reset loads stretch one, giving three cycle moves.
// - nonzero stretch lengthens the strobe and all related bus timing; here ALE and address drive widths stay fixed.
// - stretch affects external data moves only, never program fetch.
// - software may rewrite stretch anytime; later moves use it.
// - first 16-bit pointer, low and high bytes at two consecutive offsets.
// - second 16-bit pointer with its own two byte offsets.
// - select register holds choice in bit 0; other bits read zero.
// - all pointer operations use the pointer the select bit names.
// - incrementing the select register toggles the active pointer.
// - reset clears the select bit, first pointer active.
// - one machine cycle is four clocks; counts scale by it.
// - low address multiplexed with data on one port, high on another.
module mvx_top
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire mvx_pkg::mvx_byte_t sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire mvx_pkg::mvx_byte_t sfr_wdata_in,
    output mvx_pkg::mvx_byte_t sfr_rdata_out,
    input wire logic [4:0] clkctl_upper_in,
    input wire logic ptr_load_in,
    input wire mvx_pkg::mvx_addr_t ptr_load_val_in,
    input wire logic ptr_inc_in,
    input wire logic xmove_req_in,
    input wire logic xmove_write_in,
    input wire logic xmove_use_ri_in,
    input wire mvx_pkg::mvx_byte_t xmove_ri_addr_in,
    input wire mvx_pkg::mvx_byte_t xmove_page_in,
    input wire mvx_pkg::mvx_byte_t xmove_wdata_in,
    output logic xmove_busy_out,
    output logic xmove_done_out,
    output mvx_pkg::mvx_byte_t xmove_rdata_out,
    output mvx_pkg::mvx_stretch_t stretch_out,
    output logic ale_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output mvx_pkg::mvx_byte_t low_address_data_port_out,
    output logic low_address_data_port_oe_n_out,
    input wire mvx_pkg::mvx_byte_t low_address_data_port_in,
    output mvx_pkg::mvx_byte_t high_address_port_out
);
    import mvx_pkg::*;

    // index window test, shared by the latch enable and the low port drive
    function automatic logic in_addr_window(input mvx_state_t st, input mvx_count_t c,
                                            input mvx_count_t lim);
        in_addr_window = (st == mvx_st_addr) && (c < lim);
    endfunction : in_addr_window

    // strobe decode, shared by the read and the write pin
    function automatic logic strobe_low(input mvx_state_t st, input logic is_write,
                                        input logic want_write);
        strobe_low = (st == mvx_st_strobe) && (is_write == want_write);
    endfunction : strobe_low

    mvx_reg_if rif();
    mvx_plan_if pif();

    // register file: pointers, select bit, stretch field
    assign rif.sfr_addr = sfr_addr_in;
    assign rif.sfr_wr = sfr_wr_in;
    assign rif.sfr_wdata = sfr_wdata_in;
    assign rif.clkctl_upper = clkctl_upper_in;
    assign rif.ptr_load = ptr_load_in;
    assign rif.ptr_load_val = ptr_load_val_in;
    assign rif.ptr_inc = ptr_inc_in;

    mvx_sfr_regs u_regs
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .rif(rif)
    );

    mvx_cycle_plan u_plan
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pif(pif)
    );

    assign sfr_rdata_out = rif.sfr_rdata;
    assign stretch_out = rif.stretch;

    // request acceptance: a request while a move runs is dropped, not queued
    mvx_state_t state_q, state_d;
    mvx_count_t cnt_q, cnt_d;
    logic accept;
    assign accept = xmove_req_in && (state_q == mvx_st_idle);

    // stretch is sampled once per move, when the request is taken
    assign pif.load = accept;
    assign pif.stretch = rif.stretch;

    // capture group: address, direction and write data held for the move
    // the pointer is read as it stands, so a load in the accepting cycle is not seen
    mvx_addr_t addr_q, addr_d;
    mvx_byte_t wdata_q, wdata_d;
    logic write_q, write_d;

    always_comb
    begin
        addr_d = addr_q;
        wdata_d = wdata_q;
        write_d = write_q;
        if (accept)
        begin
            if (xmove_use_ri_in)
                addr_d = {xmove_page_in, xmove_ri_addr_in};
            else
                addr_d = rif.active_ptr;
            wdata_d = xmove_wdata_in;
            write_d = xmove_write_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            addr_q <= `MVX_PTR_RESET;
            wdata_q <= `MVX_BYTE_ZERO;
            write_q <= 1'b0;
        end
        else
        begin
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            write_q <= write_d;
        end
    end

    // sequencer group: clock index within the move and phase
    logic done_d;
    logic at_end;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        done_d = 1'b0;
        at_end = (cnt_q == pif.move_last);
        case (state_q)
            mvx_st_idle:
            begin
                if (accept)
                begin
                    state_d = mvx_st_addr;
                    cnt_d = `MVX_CNT_FIRST;
                end
            end
            mvx_st_addr, mvx_st_strobe, mvx_st_recov:
            begin
                if (at_end)
                begin
                    state_d = mvx_st_idle;
                    cnt_d = `MVX_CNT_FIRST;
                    done_d = 1'b1;
                end
                else
                begin
                    cnt_d = 6'(cnt_q + `MVX_CNT_STEP);
                    if (cnt_d < pif.strobe_first)
                        state_d = mvx_st_addr;
                    else if (cnt_d <= pif.strobe_last)
                        state_d = mvx_st_strobe;
                    else
                        state_d = mvx_st_recov;
                end
            end
            default:
            begin
                state_d = mvx_st_idle;
                cnt_d = `MVX_CNT_FIRST;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= mvx_st_idle;
            cnt_q <= `MVX_CNT_FIRST;
            xmove_done_out <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            xmove_done_out <= done_d;
        end
    end

    // read capture group: the port byte is taken in the last strobe clock,
    // while the part still drives it, and held until the next read
    mvx_byte_t rdata_d;
    logic rd_take;

    always_comb
    begin
        rd_take = (state_q == mvx_st_strobe) && (cnt_q == pif.strobe_last) && !write_q;
        rdata_d = xmove_rdata_out;
        if (rd_take)
            rdata_d = low_address_data_port_in;
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            xmove_rdata_out <= `MVX_BYTE_ZERO;
        else
            xmove_rdata_out <= rdata_d;
    end

    // control pin group: every pin is the registered image of the next phase,
    // so the pins line up with state_q and never glitch
    logic ale_d, rd_n_d, wr_n_d, busy_d;
    mvx_addr_t next_addr;
    logic next_write;

    always_comb
    begin
        next_addr = addr_q;
        next_write = write_q;
        if (accept)
        begin
            next_addr = addr_d;
            next_write = write_d;
        end
        busy_d = (state_d != mvx_st_idle);
        ale_d = in_addr_window(state_d, cnt_d, `MVX_ALE_CLKS);
        rd_n_d = !strobe_low(state_d, next_write, 1'b0);
        wr_n_d = !strobe_low(state_d, next_write, 1'b1);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ale_out <= 1'b0;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
            xmove_busy_out <= 1'b0;
        end
        else
        begin
            ale_out <= ale_d;
            rd_n_out <= rd_n_d;
            wr_n_out <= wr_n_d;
            xmove_busy_out <= busy_d;
        end
    end

    // port group: low port carries address then write data, high port the high address byte
    logic oe_n_d;
    mvx_byte_t p0_d, p2_d;
    logic addr_phase, data_phase;

    always_comb
    begin
        addr_phase = in_addr_window(state_d, cnt_d, `MVX_ADDR_DRIVE_CLKS);
        // write data held one clock past the strobe for hold time
        data_phase = busy_d && next_write && !addr_phase &&
                     (cnt_d <= 6'(pif.strobe_last + `MVX_CNT_STEP));
        oe_n_d = !(addr_phase || data_phase);
        p0_d = low_address_data_port_out;
        if (addr_phase)
            p0_d = next_addr[7:0];
        else if (data_phase)
            p0_d = wdata_q;
        // high byte stays out for the whole move, then holds
        p2_d = high_address_port_out;
        if (busy_d)
            p2_d = next_addr[15:8];
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            low_address_data_port_oe_n_out <= 1'b1;
            low_address_data_port_out <= `MVX_BYTE_ZERO;
            high_address_port_out <= `MVX_BYTE_ZERO;
        end
        else
        begin
            low_address_data_port_oe_n_out <= oe_n_d;
            low_address_data_port_out <= p0_d;
            high_address_port_out <= p2_d;
        end
    end
endmodule : mvx_top

// >>> testbench/mvx_sva.sv
// Purpose: port checks of the external data move sequencer
// Assumes: one clock, async active-high reset
// Notes: index counter follows each move from its accepting edge
`timescale 1ns/1ns
`include "mvx_params.svh"
module mvx_sva
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire mvx_pkg::mvx_byte_t sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire mvx_pkg::mvx_byte_t sfr_wdata_in,
    input wire mvx_pkg::mvx_byte_t sfr_rdata_out,
    input wire logic [4:0] clkctl_upper_in,
    input wire logic xmove_req_in,
    input wire logic xmove_busy_out,
    input wire logic xmove_done_out,
    input wire mvx_pkg::mvx_stretch_t stretch_out,
    input wire logic ale_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out,
    input wire logic low_address_data_port_oe_n_out
);
    import mvx_pkg::*;
    mvx_count_t idx_q, idx_d, wid_q, wid_d, wexp, mlen;
    mvx_stretch_t s_q, s_d;
    logic take;
    assign take = xmove_req_in && !xmove_busy_out;
    assign wexp = (s_q == 3'h0) ? 6'h02 : {1'b0, s_q, 2'b00};
    assign mlen = {1'b0, s_q, 2'b00} + 6'h08;
    always_comb
    begin
        idx_d = take ? 6'h00 : idx_q + 6'h01;
        s_d = take ? stretch_out : s_q;
        wid_d = (rd_n_out && wr_n_out) ? 6'h00 : wid_q + 6'h01;
    end
    // idle wrap of the index is harmless: only busy or done cycles are judged
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            idx_q <= 6'h00;
            s_q <= 3'h1;
            wid_q <= 6'h00;
        end
        else
        begin
            idx_q <= idx_d;
            s_q <= s_d;
            wid_q <= wid_d;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    sequence move_taken;
        take;
    endsequence
    sequence addr_phase;
        ale_out [*2] ##1 !ale_out;
    endsequence
    move_start_a: assert property (move_taken |=> addr_phase)
        else $error("address latch phase wrong");
    move_length_a: assert property (xmove_done_out |-> idx_q == mlen && !xmove_busy_out)
        else $error("move length wrong");
    busy_span_a: assert property (xmove_busy_out |-> idx_q < mlen)
        else $error("busy past move end");
    strobe_width_a: assert property ($rose(rd_n_out && wr_n_out) |-> wid_q == wexp)
        else $error("strobe width wrong");
    strobe_in_move_a: assert property (!(rd_n_out && wr_n_out) |-> xmove_busy_out)
        else $error("strobe outside a move");
    write_drive_a: assert property (!wr_n_out |-> !low_address_data_port_oe_n_out)
        else $error("port released during write strobe");
    stretch_write_a: assert property (sfr_wr_in && sfr_addr_in == `MVX_OFF_CLKCTL |=>
        {5'h00, stretch_out} == ($past(sfr_wdata_in) & 8'h07)) else $error("stretch not taken");
    select_read_a: assert property (sfr_addr_in == `MVX_OFF_SELECT |=>
        sfr_rdata_out[7:1] == 7'h00) else $error("select upper bits not zero");
    clkctl_read_a: assert property (sfr_addr_in == `MVX_OFF_CLKCTL |=>
        sfr_rdata_out == {$past(clkctl_upper_in), $past(stretch_out)})
        else $error("clock control readback wrong");
    done_pulse_a: assert property (xmove_done_out |=> !xmove_done_out)
        else $error("done longer than one cycle");
endmodule : mvx_sva

// >>> testbench/mvx_ext_mem.sv
// Purpose: external data RAM on the multiplexed low port
// Assumes: low address latched while ale is high
// Notes: a released port shows the inverse of its last byte, never a held value
`timescale 1ns/1ns
module mvx_ext_mem
(
    input wire logic clk_in,
    input wire logic ale_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire mvx_pkg::mvx_byte_t port_in,
    input wire mvx_pkg::mvx_byte_t high_in,
    output mvx_pkg::mvx_byte_t port_out
);
    import mvx_pkg::*;
    mvx_byte_t mem [0:65535];
    mvx_byte_t lo_q = 8'h00;
    mvx_byte_t last_q = 8'h00;
    always @(posedge clk_in)
    begin
        if (ale_in)
            lo_q <= port_in;
        if (!wr_n_in)
            mem[{high_in, lo_q}] <= port_in;
        last_q <= port_in;
    end
    assign port_out = !rd_n_in ? mem[{high_in, lo_q}] : ~last_q;
endmodule : mvx_ext_mem

// >>> testbench/tb_external_data_move_stretch_dual_pointer.sv
// Purpose: self-checking bench of the external data move block
// Assumes: inputs change at the falling edge
// Notes: every stretch value is walked once with a write and a read
`timescale 1ns/1ns
module tb_external_data_move_stretch_dual_pointer;
    import mvx_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, swr = 1'b0, ld = 1'b0, inc = 1'b0;
    logic req = 1'b0, wr = 1'b0, ri = 1'b0, busy, done, ale, rd_n, wr_n, oe_n;
    logic [4:0] upper = 5'h15;
    mvx_byte_t addr = 8'h00, wdata = 8'h00, ri_a = 8'h00, page = 8'h00, xdata = 8'h00;
    mvx_byte_t rdata, xrdata, p0_out, p2, p0_wire, mem_out;
    mvx_addr_t ld_val = 16'h0000;
    mvx_stretch_t stretch, cur_s = 3'h1;
    int n_errors = 0, n_compared = 0, n_cycles = 0;
    assign p0_wire = oe_n ? mem_out : p0_out;
    mvx_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wr_in(swr),
        .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .clkctl_upper_in(upper),
        .ptr_load_in(ld), .ptr_load_val_in(ld_val), .ptr_inc_in(inc), .xmove_req_in(req),
        .xmove_write_in(wr), .xmove_use_ri_in(ri), .xmove_ri_addr_in(ri_a),
        .xmove_page_in(page), .xmove_wdata_in(xdata), .xmove_busy_out(busy),
        .xmove_done_out(done), .xmove_rdata_out(xrdata), .stretch_out(stretch),
        .ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n), .low_address_data_port_out(p0_out),
        .low_address_data_port_oe_n_out(oe_n), .low_address_data_port_in(p0_wire),
        .high_address_port_out(p2));
    mvx_ext_mem u_mem (.clk_in(clk_in), .ale_in(ale), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .port_in(p0_wire), .high_in(p2), .port_out(mem_out));
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end
    task automatic print_verdict();
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk_in)
    begin
        n_cycles++;
        if (n_cycles == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic reg_wr(input mvx_byte_t a, input mvx_byte_t d);
        addr = a;
        wdata = d;
        swr = 1'b1;
        if (a == 8'h8E)
            cur_s = d[2:0];
        @(negedge clk_in);
        swr = 1'b0;
        // idle edge, so back-to-back writes never toggle the strobe in one step
        @(negedge clk_in);
    endtask : reg_wr
    task automatic reg_chk(input mvx_byte_t a, input mvx_byte_t e);
        addr = a;
        @(negedge clk_in);
        cmp("register", {8'h00, e}, {8'h00, rdata});
    endtask : reg_chk
    task automatic ptr_op(input logic load, input mvx_addr_t v);
        ld = load;
        inc = !load;
        ld_val = v;
        @(negedge clk_in);
        ld = 1'b0;
        inc = 1'b0;
        @(negedge clk_in);
    endtask : ptr_op
    // optional stretch rewrite lands one cycle into the move
    task automatic xmove(input logic w, input logic r, input mvx_byte_t d, input logic rew);
        int n;
        int s;
        s = cur_s;
        wr = w;
        ri = r;
        xdata = d;
        req = 1'b1;
        @(negedge clk_in);
        req = 1'b0;
        n = 1;
        if (rew)
        begin
            reg_wr(8'h8E, 8'h00);
            n = 2;
        end
        else
            @(negedge clk_in);
        while (done !== 1'b1 && n < 60)
        begin
            @(negedge clk_in);
            n++;
        end
        cmp("move length", 16'(4 * (s + 2)), 16'(n));
    endtask : xmove
    task automatic t_reset();
        cmp("stretch", 16'h0001, {13'h0000, stretch});
        reg_chk(8'h86, 8'h00);
        for (int i = 0; i < 4; i++)
            reg_chk(8'h82 + 8'(i), 8'h00);
        reg_chk(8'h8E, 8'hA9);
        ri_a = 8'h10;
        page = 8'h20;
        xmove(1'b1, 1'b1, 8'h3C, 1'b0);
        cmp("ram", 16'h003C, {8'h00, u_mem.mem[16'h2010]});
    endtask : t_reset
    task automatic t_regs();
        for (int i = 0; i < 4; i++)
            reg_wr(8'h82 + 8'(i), 8'h11 * 8'(i + 1));
        for (int i = 0; i < 4; i++)
            reg_chk(8'h82 + 8'(i), 8'h11 * 8'(i + 1));
        reg_wr(8'h86, 8'hFF);
        reg_chk(8'h86, 8'h01);
        reg_wr(8'h90, 8'h5A);
        reg_chk(8'h90, 8'h00);
        reg_wr(8'h8E, 8'hFF);
        upper = 5'h0A;
        reg_chk(8'h8E, 8'h57);
    endtask : t_regs
    task automatic t_stretch();
        reg_wr(8'h86, 8'h00);
        for (int s = 0; s < 8; s++)
        begin
            reg_wr(8'h8E, 8'(s));
            cmp("stretch", 16'(s), {13'h0000, stretch});
            ptr_op(1'b1, 16'h1200 + 16'(s));
            xmove(1'b1, 1'b0, 8'hA5 ^ 8'(s), 1'b0);
            cmp("ram", {8'h00, 8'hA5 ^ 8'(s)}, {8'h00, u_mem.mem[16'h1200 + 16'(s)]});
            xmove(1'b0, 1'b0, 8'h00, 1'b0);
            cmp("read byte", {8'h00, 8'hA5 ^ 8'(s)}, {8'h00, xrdata});
        end
    endtask : t_stretch
    task automatic t_dual();
        reg_wr(8'h8E, 8'h00);
        ptr_op(1'b1, 16'h3000);
        reg_wr(8'h86, 8'h01);
        ptr_op(1'b1, 16'h4000);
        ptr_op(1'b0, 16'h0000);
        reg_chk(8'h84, 8'h01);
        reg_chk(8'h83, 8'h30);
        xmove(1'b1, 1'b0, 8'h66, 1'b0);
        cmp("ram", 16'h0066, {8'h00, u_mem.mem[16'h4001]});
        reg_wr(8'h86, 8'h02);
        reg_chk(8'h86, 8'h00);
        xmove(1'b1, 1'b0, 8'h77, 1'b0);
        cmp("ram", 16'h0077, {8'h00, u_mem.mem[16'h3000]});
    endtask : t_dual
    task automatic t_rewrite();
        reg_wr(8'h8E, 8'h02);
        ri_a = 8'hC3;
        page = 8'h5A;
        xmove(1'b1, 1'b1, 8'h99, 1'b1);
        cmp("ram", 16'h0099, {8'h00, u_mem.mem[16'h5AC3]});
        xmove(1'b0, 1'b1, 8'h00, 1'b0);
        cmp("read byte", 16'h0099, {8'h00, xrdata});
    endtask : t_rewrite
    initial
    begin
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset();
        t_regs();
        t_stretch();
        t_dual();
        t_rewrite();
        print_verdict();
    end
endmodule : tb_external_data_move_stretch_dual_pointer
bind mvx_top mvx_sva u_sva (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .clkctl_upper_in(clkctl_upper_in), .xmove_req_in(xmove_req_in),
    .xmove_busy_out(xmove_busy_out), .xmove_done_out(xmove_done_out),
    .stretch_out(stretch_out), .ale_out(ale_out), .rd_n_out(rd_n_out), .wr_n_out(wr_n_out),
    .low_address_data_port_oe_n_out(low_address_data_port_oe_n_out));
